// ### logic/pbd_defs.svh
// Constants of the peripheral register window decoder.
// Assumes a 20-bit core address and a 16-bit peripheral bus.
// Operation
// [R01] Decode 256-byte window, memory or I/O space
// [R02] Peripheral registers sit at fixed window offsets
// [R03] Relocation register at offset 0A8H, moves along
// [R04] Reset value 00FFH: window at I/O 0FF00H
// [R05] One relocation bit traps coprocessor escapes
// [R06] Peripheral bus always carries 16-bit data
// [R07] Unassigned window writes store nothing
// [R08] Window hits also run an external cycle
// [R09] Narrow bus word access uses two cycles
// [R10] Window hits make internal ready, ignore external
// [R11] Zero waits, timer registers take one
// [R12] Every write moves a full word
// [R13] Odd byte write: low byte high, swapped
// [R14] Odd word write: bytes swapped, one below
// [R15] Odd word read returns swapped bytes
// [R16] Byte read updates only the low byte
// [R17] Software reads registers with aligned words
// [R18] Software relocates narrow bus with byte writes
// [R19] Software avoids unaligned byte writes
// [R20] Reserved reads undefined, software writes zero
// [R21] Base and space bit compared per cycle
// [R22] Relocation write applies from next cycle
`ifndef PBD_DEFS_SVH
`define PBD_DEFS_SVH
`define PBD_RELOC_OFS 8'ha8
`define PBD_RELOC_RST 16'h00ff
`define PBD_BASE_MSB 11
`define PBD_MEM_BIT 12
`define PBD_ESC_BIT 14
`define PBD_RELOC_MASK 16'h5fff
`define PBD_TMR_LO 8'h30
`define PBD_TMR_HI 8'h46
`define PBD_IC_LO 8'h02
`define PBD_IC_HI 8'h1e
`define PBD_T2_RSV 8'h44
`define PBD_PORT_LO 8'h50
`define PBD_PORT_HI 8'h6a
`define PBD_SER1_LO 8'h70
`define PBD_SER1_HI 8'h7a
`define PBD_CS_LO 8'h80
`define PBD_CS_HI 8'ha8
`define PBD_REF_LO 8'hb0
`define PBD_REF_HI 8'hb8
`define PBD_STEP 8'hbc
`endif

// ### logic/pbd_pkg.sv
// Types shared by the peripheral register window decoder.
// Assumes the core presents one cycle request at a time.
package pbd_pkg;
   typedef struct packed
   {
      logic [19:0] addr;
      logic io;
      logic wr;
      logic word;
      logic [15:0] acc;
   } pbd_cyc_s;
   typedef struct packed
   {
      logic [19:0] addr;
      logic io;
      logic wr;
      logic [15:0] data;
   } pbd_ext_s;
   typedef enum logic [1:0]
   {
      PBD_IDLE = 2'h0,
      PBD_XFER = 2'h1,
      PBD_TWAIT = 2'h3,
      PBD_SECOND = 2'h2
   } pbd_state_e;
endpackage

// ### logic/pbd_decoder.sv
// Address decode, ready and byte steering of the peripheral register window.
// Assumes the core bus unit issues one request at a time and waits for ready;
// peripherals answer FB_RDATA combinationally in the cycle FB_RD is high.
`timescale 1ns/100ps
`include "pbd_defs.svh"
module pbd_decoder
#(
   parameter bit NARROW_BUS = 1'b0
)
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CYC_START,
   input wire pbd_pkg::pbd_cyc_s CYC_REQ,
   input wire logic EXT_READY,
   input wire logic [15:0] FB_RDATA,
   output logic CYC_HIT,
   output logic CYC_READY,
   output logic [15:0] CYC_RDATA,
   output logic CYC_LOW_ONLY,
   output logic ESC_TRAP,
   output logic [7:0] FB_ADDR,
   output logic FB_WR,
   output logic FB_RD,
   output logic [15:0] FB_WDATA,
   output logic EXT_CYCLE,
   output pbd_pkg::pbd_ext_s EXT_BUS
);
   import pbd_pkg::*;

   pbd_state_e state, next_state;
   pbd_cyc_s req, next_req;
   pbd_ext_s ext, next_ext;
   logic [15:0] reloc, next_reloc;
   logic [15:0] rdata, next_rdata;
   logic [15:0] fb_wdata, next_fb_wdata;
   logic [7:0] fb_addr, next_fb_addr;
   logic hit, next_hit;
   logic ready, next_ready;
   logic low_only, next_low_only;
   logic fb_wr, next_fb_wr;
   logic fb_rd, next_fb_rd;
   logic ext_cyc, next_ext_cyc;
   logic timer, next_timer;
   logic rdy_meta, rdy_sync;
   logic cur_hit, cur_timer, xfer_end;
   logic [15:0] word_in;
   logic [19:0] addr_up;

   // Window hit against the base and space held now
   function automatic logic win_hit(input logic [19:0] a, input logic io,
                                    input logic [15:0] rr);
      win_hit = (a[19:8] == rr[`PBD_BASE_MSB:0]) && (io == !rr[`PBD_MEM_BIT]);
   endfunction

   // Offsets that belong to a peripheral; all others are reserved
   function automatic logic assigned(input logic [7:0] o);
      assigned = ((o >= `PBD_IC_LO) && (o <= `PBD_IC_HI))
               || ((o >= `PBD_TMR_LO) && (o <= `PBD_TMR_HI) && (o != `PBD_T2_RSV))
               || ((o >= `PBD_PORT_LO) && (o <= `PBD_PORT_HI))
               || ((o >= `PBD_SER1_LO) && (o <= `PBD_SER1_HI))
               || ((o >= `PBD_CS_LO) && (o <= `PBD_CS_HI))
               || ((o >= `PBD_REF_LO) && (o <= `PBD_REF_HI))
               || (o == `PBD_STEP);
   endfunction

   // Timer registers share their storage with the counter element
   function automatic logic is_timer(input logic [7:0] o);
      is_timer = (o >= `PBD_TMR_LO) && (o <= `PBD_TMR_HI);
   endfunction

   // Odd addresses land on the word below with the bytes swapped
   function automatic logic [15:0] steer(input logic odd, input logic [15:0] d);
      steer = odd ? {d[7:0], d[15:8]} : d;
   endfunction

   // External ready comes from a pin, so it is synchronised first
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         rdy_meta <= 1'b0;
         rdy_sync <= 1'b0;
      end
      else
      begin
         rdy_meta <= EXT_READY;
         rdy_sync <= rdy_meta;
      end
   end

   // Decode terms of the request now offered and of the second half
   always_comb
   begin
      cur_hit = win_hit(CYC_REQ.addr, CYC_REQ.io, reloc); // [R01] [R21]
      cur_timer = is_timer({CYC_REQ.addr[7:1], 1'b0});
      xfer_end = ((state == PBD_XFER) && !timer) || (state == PBD_TWAIT); // [R11]
      addr_up = req.addr + 20'h00001;
      // Reserved words read as zero; the relocation word is held here
      if (fb_addr == `PBD_RELOC_OFS)
         word_in = reloc;
      else if (assigned(fb_addr))
         word_in = FB_RDATA; // [R02] [R20]
      else
         word_in = 16'h0000;
   end

   // Next values of the cycle sequencer and its registers
   always_comb
   begin
      next_state = state;
      next_req = req;
      next_ext = ext;
      next_reloc = reloc;
      next_rdata = rdata;
      next_fb_wdata = fb_wdata;
      next_fb_addr = fb_addr;
      next_hit = hit;
      next_ready = 1'b0;
      next_low_only = low_only;
      next_fb_wr = 1'b0;
      next_fb_rd = fb_rd;
      next_ext_cyc = 1'b0;
      next_timer = timer;
      case (state)
         PBD_IDLE:
         begin
            if (CYC_START && cur_hit)
            begin
               next_req = CYC_REQ;
               next_hit = 1'b1;
               next_state = PBD_XFER;
               next_timer = cur_timer;
               next_fb_addr = {CYC_REQ.addr[7:1], 1'b0}; // [R13] [R14]
               // Full word always written, so reserved words are simply not strobed
               next_fb_wr = CYC_REQ.wr && assigned({CYC_REQ.addr[7:1], 1'b0}); // [R07]
               next_fb_rd = !CYC_REQ.wr;
               next_fb_wdata = steer(CYC_REQ.addr[0], CYC_REQ.acc); // [R06] [R12] [R13] [R14]
               next_low_only = !CYC_REQ.wr && !CYC_REQ.word; // [R16]
               next_ext_cyc = 1'b1; // [R08]
               next_ext = '{addr: CYC_REQ.addr, io: CYC_REQ.io, wr: CYC_REQ.wr,
                            data: CYC_REQ.acc};
               if (CYC_REQ.wr && ({CYC_REQ.addr[7:1], 1'b0} == `PBD_RELOC_OFS))
                  next_reloc = steer(CYC_REQ.addr[0], CYC_REQ.acc)
                             & `PBD_RELOC_MASK; // [R03] [R05] [R22]
            end
         end
         PBD_XFER:
         begin
            if (timer)
               next_state = PBD_TWAIT; // [R11]
         end
         PBD_TWAIT:
         begin
            next_state = PBD_TWAIT;
         end
         PBD_SECOND:
         begin
            // The second half is decoded against the base in force now
            if (win_hit(ext.addr, ext.io, reloc) || rdy_sync) // [R10] [R22]
            begin
               next_state = PBD_IDLE;
               next_ready = 1'b1;
               next_hit = 1'b0;
            end
         end
         default:
         begin
            next_state = PBD_IDLE;
         end
      endcase
      // Peripheral data is only sampled at the end of the transfer
      if (xfer_end)
      begin
         next_fb_rd = 1'b0;
         // Writes leave the last read result standing for the core
         if (!req.wr)
         begin
            if (req.word)
               next_rdata = steer(req.addr[0], word_in); // [R15]
            else
               next_rdata = {req.acc[15:8], req.addr[0] ? word_in[15:8] : word_in[7:0]}; // [R16]
         end
         if (NARROW_BUS && req.word)
         begin
            next_state = PBD_SECOND; // [R09]
            next_ext_cyc = 1'b1;
            next_ext.addr = addr_up;
            next_ext.data = {8'h00, req.acc[15:8]};
         end
         else
         begin
            next_state = PBD_IDLE;
            next_ready = 1'b1; // [R10]
            next_hit = 1'b0;
         end
      end
   end

   // Registers of the sequencer; external ready never gates the window
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         state <= PBD_IDLE;
         req <= '0;
         ext <= '0;
         reloc <= `PBD_RELOC_RST; // [R04]
         rdata <= 16'h0000;
         fb_wdata <= 16'h0000;
         fb_addr <= 8'h00;
         hit <= 1'b0;
         ready <= 1'b0;
         low_only <= 1'b0;
         fb_wr <= 1'b0;
         fb_rd <= 1'b0;
         ext_cyc <= 1'b0;
         timer <= 1'b0;
      end
      else
      begin
         state <= next_state;
         req <= next_req;
         ext <= next_ext;
         reloc <= next_reloc;
         rdata <= next_rdata;
         fb_wdata <= next_fb_wdata;
         fb_addr <= next_fb_addr;
         hit <= next_hit;
         ready <= next_ready;
         low_only <= next_low_only;
         fb_wr <= next_fb_wr;
         fb_rd <= next_fb_rd;
         ext_cyc <= next_ext_cyc;
         timer <= next_timer;
      end
   end

   // Ports straight from the flip-flops
   assign CYC_HIT = hit;
   assign CYC_READY = ready;
   assign CYC_RDATA = rdata;
   assign CYC_LOW_ONLY = low_only;
   assign ESC_TRAP = reloc[`PBD_ESC_BIT];
   assign FB_ADDR = fb_addr;
   assign FB_WR = fb_wr;
   assign FB_RD = fb_rd;
   assign FB_WDATA = fb_wdata;
   assign EXT_CYCLE = ext_cyc;
   assign EXT_BUS = ext;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   sequence s_take;
      (state == PBD_IDLE) && CYC_START && cur_hit && !(NARROW_BUS && CYC_REQ.word);
   endsequence

   sequence s_take_word;
      (state == PBD_IDLE) && CYC_START && cur_hit && !cur_timer && NARROW_BUS && CYC_REQ.word;
   endsequence

   sequence s_one_wait;
      !CYC_READY ##1 !CYC_READY ##1 CYC_READY;
   endsequence

   // The default disable would hide this check, so it is switched off here
   a_reset_value: assert property (disable iff (1'b0) RST ##1 !RST |-> // [R04]
      reloc == `PBD_RELOC_RST && !ESC_TRAP)
      else $error("relocation reset value wrong");
   a_fast_ready: assert property (s_take and !cur_timer |-> ##2 CYC_READY) // [R11]
      else $error("window access not ready after zero waits");
   a_timer_wait: assert property (s_take and cur_timer |-> ##1 s_one_wait) // [R11]
      else $error("timer access without one wait state");
   a_ext_mirror: assert property (s_take |=> EXT_CYCLE // [R08]
      && EXT_BUS.addr == $past(CYC_REQ.addr))
      else $error("no external cycle mirrored");
   a_narrow_split: assert property (s_take_word |-> ##2 EXT_CYCLE // [R09]
      && EXT_BUS.addr == $past(CYC_REQ.addr, 2) + 20'h00001)
      else $error("narrow word access without second cycle");
   a_own_ready: assert property ((state == PBD_SECOND) && win_hit(ext.addr, ext.io, reloc) // [R10]
      |=> CYC_READY)
      else $error("second half inside window not made ready");
   a_miss_ignored: assert property ((state == PBD_IDLE) && CYC_START && !cur_hit // [R21]
      |=> !CYC_HIT && !EXT_CYCLE)
      else $error("request outside the window was taken");
   a_unassigned_wr: assert property (FB_WR |-> assigned(FB_ADDR)) // [R07]
      else $error("write strobed to reserved location");
   a_reloc_move: assert property (s_take and CYC_REQ.wr && !CYC_REQ.addr[0] // [R03]
      && CYC_REQ.addr[7:0] == `PBD_RELOC_OFS |=> reloc == ($past(CYC_REQ.acc)
      & `PBD_RELOC_MASK))
      else $error("relocation write not applied");
   a_odd_steer: assert property (FB_WR && req.addr[0] |-> // [R13]
      FB_WDATA == {req.acc[7:0], req.acc[15:8]})
      else $error("odd write not swapped");
   a_even_word: assert property (FB_WR && !req.addr[0] |-> FB_WDATA == req.acc) // [R12]
      else $error("even write not full word");
   a_byte_read: assert property (CYC_READY && CYC_LOW_ONLY |-> // [R16]
      CYC_RDATA[15:8] == req.acc[15:8])
      else $error("byte read disturbed high byte");
   a_reserved_read: assert property (CYC_READY && !req.wr && req.word && !req.addr[0] // [R20]
      && !assigned(req.addr[7:0]) |-> CYC_RDATA == 16'h0000)
      else $error("reserved word read not zero");
   a_escape_bit: assert property (s_take and CYC_REQ.wr // [R05]
      && CYC_REQ.addr[7:0] == `PBD_RELOC_OFS |=> ESC_TRAP == $past(CYC_REQ.acc[`PBD_ESC_BIT]))
      else $error("escape trap not from relocation bit");
endmodule

// ### tb/pbd_fbus_model.sv
// Peripheral register model on the 16-bit peripheral bus.
// Assumes one-cycle write strobes and read data wanted while the strobe is high.
`timescale 1ns/100ps
module pbd_fbus_model
(
   input wire logic mclk,
   input wire logic [7:0] fb_addr,
   input wire logic fb_wr,
   input wire logic fb_rd,
   input wire logic [15:0] fb_wdata,
   output logic [15:0] fb_rdata
);
   logic [15:0] mem [128];
   logic [15:0] junk;
   // Whole words stored at fixed offsets
   always @(posedge mclk)
   begin
      if (fb_wr)
         mem[fb_addr[7:1]] <= fb_wdata;
      junk <= ~junk + 16'h1357;
   end
   // Off strobe the bus shows a changing pattern, so stale data never looks right
   assign fb_rdata = fb_rd ? mem[fb_addr[7:1]] : junk;
   initial
   begin
      junk = 16'h0;
      foreach (mem[i])
         mem[i] = 16'h0;
   end
endmodule

// ### tb/peripheral_block_decoder_tb_top.sv
// Self-checking bench of the peripheral register window decoder.
// Assumes both bus variants side by side, each with a peripheral bus model.
`timescale 1ns/100ps
`define CHK(g, e) \
begin \
   samples_checked++; \
   if ((g) !== (e)) \
   begin \
      err_total++; \
      $display("[ERR] %0t got %h exp %h", $time, g, e); \
   end \
end
module peripheral_block_decoder_tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cyc_start = 1'b0;
   logic ext_ready = 1'b0;
   pbd_pkg::pbd_cyc_s cyc_req = '0;
   pbd_pkg::pbd_ext_s ext_bus;
   logic cyc_hit, cyc_ready, cyc_low_only, esc_trap, fb_wr, fb_rd, ext_cycle;
   logic [15:0] cyc_rdata, fb_rdata, fb_wdata;
   logic [7:0] fb_addr;
   logic n_ready, n_ext_cycle, n_fb_wr, n_fb_rd;
   logic [15:0] n_rdata, n_fb_rdata, n_fb_wdata;
   logic [7:0] n_fb_addr;
   pbd_pkg::pbd_ext_s n_ext_bus;
   int err_total = 0;
   int samples_checked = 0;
   pbd_decoder dut (.MCLK(mclk), .RST(rst), .CYC_START(cyc_start), .CYC_REQ(cyc_req),
      .EXT_READY(ext_ready), .FB_RDATA(fb_rdata), .CYC_HIT(cyc_hit), .CYC_READY(cyc_ready),
      .CYC_RDATA(cyc_rdata), .CYC_LOW_ONLY(cyc_low_only), .ESC_TRAP(esc_trap),
      .FB_ADDR(fb_addr), .FB_WR(fb_wr), .FB_RD(fb_rd), .FB_WDATA(fb_wdata),
      .EXT_CYCLE(ext_cycle), .EXT_BUS(ext_bus));
   pbd_fbus_model fbus (.mclk(mclk), .fb_addr(fb_addr), .fb_wr(fb_wr), .fb_rd(fb_rd),
      .fb_wdata(fb_wdata), .fb_rdata(fb_rdata));
   // Narrow bus variant on the same core requests; it is idle again before each new request
   pbd_decoder #(.NARROW_BUS(1'b1)) dut_n (.MCLK(mclk), .RST(rst), .CYC_START(cyc_start),
      .CYC_REQ(cyc_req), .EXT_READY(ext_ready), .FB_RDATA(n_fb_rdata), .CYC_HIT(),
      .CYC_READY(n_ready), .CYC_RDATA(n_rdata), .CYC_LOW_ONLY(), .ESC_TRAP(),
      .FB_ADDR(n_fb_addr), .FB_WR(n_fb_wr), .FB_RD(n_fb_rd), .FB_WDATA(n_fb_wdata),
      .EXT_CYCLE(n_ext_cycle), .EXT_BUS(n_ext_bus));
   pbd_fbus_model fbus_n (.mclk(mclk), .fb_addr(n_fb_addr), .fb_wr(n_fb_wr), .fb_rd(n_fb_rd),
      .fb_wdata(n_fb_wdata), .fb_rdata(n_fb_rdata));
   always #20 mclk = ~mclk;
   // Verdict and end of run; also reached when a wait runs out
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One core cycle; lat 0 means the address misses and must be ignored
   task automatic op(input logic [19:0] a, input logic io, input logic wr, input logic wd,
      input logic [15:0] acc, input int lat, input logic [15:0] exp_rd);
      int n = 1;
      logic hit = 1'b0;
      logic [3:0] ext_n = 4'h0;
      @(posedge mclk);
      cyc_start <= 1'b1;
      cyc_req <= '{a, io, wr, wd, acc};
      @(posedge mclk);
      cyc_start <= 1'b0;
      #1;
      while (cyc_ready !== 1'b1 && n < 6)
      begin
         hit = hit | cyc_hit;
         ext_n = ext_n + {3'h0, ext_cycle};
         @(posedge mclk);
         #1;
         n++;
      end
      if (lat == 0)
      begin
         `CHK({hit, cyc_ready, ext_n}, 6'h0)
         return;
      end
      if (cyc_ready !== 1'b1)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
         conclude();
      end
      `CHK(n, lat)
      `CHK({hit, cyc_hit, ext_n}, 6'h21)
      `CHK(ext_bus, {a, io, wr, acc})
      if (!wr)
      begin
         `CHK(cyc_rdata, exp_rd)
         `CHK(cyc_low_only, !wd)
      end
   endtask
   // Reset value places the window at the top of I/O space
   task automatic t_reset();
      `CHK(esc_trap, 1'b0)
      op(20'hffa8, 1, 0, 1, 16'h0, 2, 16'h00ff);
   endtask
   // Even word write and read back; external ready held low throughout
   task automatic t_even_word();
      op(20'hff02, 1, 1, 1, 16'ha5c3, 2, 16'h0);
      op(20'hff02, 1, 0, 1, 16'h0, 2, 16'ha5c3);
   endtask
   // Odd writes land swapped in the word one below
   task automatic t_odd_write();
      op(20'hff53, 1, 1, 0, 16'h1234, 2, 16'h0);
      op(20'hff52, 1, 0, 1, 16'h0, 2, 16'h3412);
      op(20'hff55, 1, 1, 1, 16'habcd, 2, 16'h0);
      op(20'hff54, 1, 0, 1, 16'h0, 2, 16'hcdab);
   endtask
   // Odd word read swaps; byte reads keep the high accumulator byte
   task automatic t_reads();
      op(20'hff53, 1, 0, 1, 16'h0, 2, 16'h1234);
      op(20'hff52, 1, 0, 0, 16'hee00, 2, 16'hee12);
      op(20'hff53, 1, 0, 0, 16'h7700, 2, 16'h7734);
   endtask
   // Timer registers take one wait state, both ends of the range
   task automatic t_timer();
      op(20'hff30, 1, 1, 1, 16'h0042, 3, 16'h0);
      op(20'hff30, 1, 0, 1, 16'h0, 3, 16'h0042);
      op(20'hff46, 1, 1, 1, 16'h0081, 3, 16'h0);
      op(20'hff46, 1, 0, 1, 16'h0, 3, 16'h0081);
   endtask
   // Unassigned location keeps nothing; software writes zero there
   task automatic t_reserved();
      op(20'hff20, 1, 1, 1, 16'h0, 2, 16'h0);
      op(20'hff20, 1, 1, 1, 16'hffff, 2, 16'h0);
      `CHK(fbus.mem[7'h10], 16'h0000)
      op(20'hff20, 1, 0, 1, 16'h0, 2, 16'h0000);
   endtask
   // Move to memory 10000H, then back to I/O with the escape trap set
   task automatic t_reloc();
      op(20'hffa8, 1, 0, 0, 16'h1100, 2, 16'h11ff);
      op(20'hffa8, 1, 1, 0, 16'h1100, 2, 16'h0);
      op(20'hff02, 1, 0, 1, 16'h0, 0, 16'h0);
      op(20'h10002, 0, 0, 1, 16'h0, 2, 16'ha5c3);
      op(20'h100a8, 0, 0, 1, 16'h0, 2, 16'h1100);
      // Narrow second half falls outside the moved window and needs external ready
      @(posedge mclk);
      ext_ready <= 1'b1;
      op(20'h100a8, 0, 1, 1, 16'h40ff, 2, 16'h0);
      `CHK(esc_trap, 1'b1)
      `CHK({n_ready, n_ext_bus.addr}, {1'b0, 20'h100a9})
      @(posedge mclk);
      ext_ready <= 1'b0;
      op(20'hffa8, 1, 0, 1, 16'h0, 2, 16'h40ff);
      op(20'hffa8, 1, 1, 1, 16'h00ff, 2, 16'h0);
      `CHK(esc_trap, 1'b0)
   endtask
   // Narrow variant: word access adds a second cycle at the next byte, made ready inside
   task automatic t_narrow();
      op(20'hff04, 1, 1, 1, 16'h5aa5, 2, 16'h0);
      `CHK({n_ext_cycle, n_ready, n_ext_bus}, {2'b10, 20'hff05, 2'b11, 16'h005a})
      @(posedge mclk);
      #1;
      `CHK({n_ready, fbus_n.mem[7'h02]}, {1'b1, 16'h5aa5})
      op(20'hff04, 1, 0, 1, 16'h0, 2, 16'h5aa5);
      `CHK(n_rdata, 16'h5aa5)
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_even_word();
      t_odd_write();
      t_reads();
      t_timer();
      t_reserved();
      t_reloc();
      t_narrow();
      conclude();
   end
endmodule
